// >>> src/tws_serial_io.sv
// three-wire serial port: control, internal clock engine, link crossing
//
// How it works
// - one frame carries eight bits, msb first, each tied to a clock pulse
// - output changes on falling clock edges, input sampled on rising edges
// - completion pulse raised at the eighth rising clock edge, or three system clocks after it with the external clock
// - internal clock stops at the eighth rise and idles high
// - shift register write starts a transfer when transmit is enabled
// - serial output floats whenever transmit enable is low
// - internal clock first falls within one serial period of start
// - send-only still shifts the input pin into the shift register
// - transmit disable mid-frame, internal clock: stop high at next clock edge, no pulse
// - external pulses before start neither shift nor change the output
// - transmit disable mid-frame, external clock: ignore pulses, no pulse
// - reception starts on receive enable rising or shift register read
// - receive disable mid-frame, internal clock: stop high at next clock edge, no pulse
// - external pulses before reception start shift nothing in
// - full duplex starts on receive enable rising or write with transmit on
// - clearing transmit enable in full duplex stops only transmission, clearing receive enable changes nothing
// - clearing both enables stops the frame, floats output, no pulse
// - both enables low resets the bit counter to realign
// - shift register content after reset is undefined
`include "tws_map.svh"

module tws_serial_io
#(
	parameter logic [7:0] DIV_HALF = `TWS_DIV_HALF
)
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        sck_link,
	input  wire logic        si,
	input  wire logic        tx_enable_bit,
	input  wire logic        rx_enable_bit,
	input  wire logic        ext_clk_sel,
	input  wire logic        wr_strobe,
	input  wire logic [7:0]  wr_data,
	input  wire logic        rd_strobe,
	output logic      [7:0]  rd_data,
	output logic             busy,
	output logic             transfer_done_irq,
	output logic             sck_o,
	output logic             sck_oe,
	output logic             so_o,
	output logic             so_oe
);

	// ****************************************************************
	// state
	// ****************************************************************
	tws_pkg::tws_state_t  state_q;
	tws_pkg::tws_state_t  state_d;
	tws_pkg::tws_byte_t   sr_q;
	tws_pkg::tws_byte_t   sr_d;
	logic [7:0]           div_q;
	logic [7:0]           div_d;
	logic [3:0]           bit_q;
	logic [3:0]           bit_d;
	logic                 sck_q;
	logic                 sck_d;
	logic                 so_int_q;
	logic                 so_int_d;
	logic                 abort_q;
	logic                 abort_d;
	logic                 hold_q;
	logic                 hold_d;
	logic                 irq_q;
	logic                 irq_d;
	logic                 rx_prev_q;
	logic                 ext_q;
	logic                 sck_oe_q;
	logic                 so_oe_q;
	logic [7:0]           rdata_q;
	logic                 si_s1_q;
	logic                 si_s2_q;
	logic                 done_s1_q;
	logic                 done_s2_q;
	logic                 done_s3_q;
	logic                 busy_q;
	logic                 busy_d;
	logic                 idle;
	logic                 int_run;
	logic                 both_off;
	logic                 rx_rise;
	logic                 wr_start;
	logic                 rd_start;
	logic                 start;
	logic                 tick;
	logic                 fall_ev;
	logic                 rise_ev;
	logic                 last_bit;
	logic                 done_rise;
	logic                 stop_now;

	tws_link_if lk ();

	tws_link_shifter u_link
	(
		.sck (sck_link),
		.si  (si),
		.lk  (lk)
	);

	// ****************************************************************
	// decode
	// ****************************************************************
	assign idle      = (state_q == tws_pkg::TWS_IDLE);
	assign int_run   = (state_q == tws_pkg::TWS_INT_RUN);
	assign both_off  = !tx_enable_bit && !rx_enable_bit;
	assign rx_rise   = rx_enable_bit && !rx_prev_q;
	assign wr_start  = wr_strobe && tx_enable_bit;
	assign rd_start  = rd_strobe && rx_enable_bit && !tx_enable_bit;
	assign start     = idle && (wr_start || rd_start || rx_rise);
	assign tick      = (div_q == (DIV_HALF - `TWS_DIV_ONE));
	assign fall_ev   = int_run && tick && sck_q;
	assign rise_ev   = int_run && tick && !sck_q;
	assign last_bit  = (bit_q == `TWS_LAST_BIT);
	assign done_rise = done_s2_q && !done_s3_q;
	assign stop_now  = abort_q || both_off;
	assign busy_d    = (state_d != tws_pkg::TWS_IDLE);

	assign lk.hold    = hold_q;
	assign lk.tx_byte = sr_q;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		state_d  = state_q;
		sr_d     = sr_q;
		div_d    = div_q;
		bit_d    = bit_q;
		sck_d    = sck_q;
		so_int_d = so_int_q;
		abort_d  = abort_q;
		hold_d   = hold_q;
		irq_d    = 1'b0;
		unique case (state_q)
			tws_pkg::TWS_IDLE:
			begin
				sck_d  = `TWS_SCK_IDLE;
				bit_d  = `TWS_CNT_ZERO;
				hold_d = 1'b1;
				if (wr_strobe)
				begin
					sr_d = wr_data;
				end
				if (start && !ext_clk_sel)
				begin
					state_d = tws_pkg::TWS_INT_RUN;
					div_d   = `TWS_DIV_ZERO;
					abort_d = 1'b0;
				end
				else if (start)
				begin
					state_d = tws_pkg::TWS_EXT_RUN;
					hold_d  = 1'b0;
				end
			end
			tws_pkg::TWS_INT_RUN:
			begin
				if (both_off)
				begin
					abort_d = 1'b1;
				end
				div_d = tick ? `TWS_DIV_ZERO : div_q + `TWS_DIV_ONE;
				if (fall_ev && stop_now)
				begin
					state_d = tws_pkg::TWS_IDLE;
				end
				else if (fall_ev)
				begin
					sck_d    = 1'b0;
					so_int_d = sr_q[7];
				end
				else if (rise_ev)
				begin
					sck_d = 1'b1;
					sr_d  = {sr_q[6:0], si_s2_q};
					bit_d = bit_q + `TWS_CNT_ONE;
					if (stop_now)
					begin
						state_d = tws_pkg::TWS_IDLE;
					end
					else if (last_bit)
					begin
						state_d = tws_pkg::TWS_IDLE;
						irq_d   = 1'b1;
					end
				end
			end
			tws_pkg::TWS_EXT_RUN:
			begin
				if (both_off)
				begin
					state_d = tws_pkg::TWS_IDLE;
					hold_d  = 1'b1;
				end
				else if (done_rise)
				begin
					state_d = tws_pkg::TWS_IDLE;
					sr_d    = lk.rx_byte;
					hold_d  = 1'b1;
					irq_d   = 1'b1;
				end
			end
			default:
			begin
				state_d = tws_pkg::TWS_IDLE;
				hold_d  = 1'b1;
			end
		endcase
	end

	// ****************************************************************
	// control registers
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			state_q  <= tws_pkg::TWS_IDLE;
			abort_q  <= 1'b0;
			hold_q   <= `TWS_HOLD_RST;
			irq_q    <= 1'b0;
			busy_q   <= 1'b0;
		end
		else if (ce)
		begin
			state_q  <= state_d;
			abort_q  <= abort_d;
			hold_q   <= hold_d;
			irq_q    <= irq_d;
			busy_q   <= busy_d;
		end
	end

	// ****************************************************************
	// internal serial clock engine
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			div_q    <= `TWS_DIV_ZERO;
			bit_q    <= `TWS_CNT_ZERO;
			sck_q    <= `TWS_SCK_IDLE;
			so_int_q <= `TWS_SO_IDLE;
		end
		else if (ce)
		begin
			div_q    <= div_d;
			bit_q    <= bit_d;
			sck_q    <= sck_d;
			so_int_q <= so_int_d;
		end
	end

	// shift register has no reset value
	always_ff @(posedge clk)
	begin
		if (ce)
		begin
			sr_q <= sr_d;
		end
	end

	// ****************************************************************
	// enable edge, pin controls, read port
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rx_prev_q <= 1'b0;
			ext_q     <= 1'b0;
			sck_oe_q  <= 1'b0;
			so_oe_q   <= 1'b0;
		end
		else if (ce)
		begin
			rx_prev_q <= rx_enable_bit;
			ext_q     <= ext_clk_sel;
			sck_oe_q  <= !ext_clk_sel;
			so_oe_q   <= tx_enable_bit;
		end
	end

	// read port copy of the shift register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata_q <= `TWS_RDATA_RST;
		end
		else if (ce)
		begin
			rdata_q <= sr_q;
		end
	end

	// ****************************************************************
	// synchronisers from the pin and the link domain
	// ****************************************************************
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			si_s1_q   <= 1'b0;
			si_s2_q   <= 1'b0;
			done_s1_q <= 1'b0;
			done_s2_q <= 1'b0;
			done_s3_q <= 1'b0;
		end
		else if (ce)
		begin
			si_s1_q   <= si;
			si_s2_q   <= si_s1_q;
			done_s1_q <= lk.done;
			done_s2_q <= done_s1_q;
			done_s3_q <= done_s2_q;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign rd_data           = rdata_q;
	assign busy              = busy_q;
	assign transfer_done_irq = irq_q;
	assign sck_o             = sck_q;
	assign sck_oe            = sck_oe_q;
	assign so_o              = ext_q ? lk.so : so_int_q;
	assign so_oe             = so_oe_q;

endmodule

// >>> src/tws_map.svh
// constants of the three-wire serial port: counts, reset values, idle levels
`ifndef TWS_MAP_SVH
`define TWS_MAP_SVH

// ****************************************************************
// frame layout
// ****************************************************************
`define TWS_BITS       8
`define TWS_LAST_BIT   4'h7
`define TWS_CNT_ZERO   4'h0
`define TWS_CNT_ONE    4'h1

// ****************************************************************
// internal serial clock
// ****************************************************************
`define TWS_DIV_HALF   8'h04
`define TWS_DIV_ZERO   8'h00
`define TWS_DIV_ONE    8'h01

// ****************************************************************
// reset and idle values
// ****************************************************************
`define TWS_SCK_IDLE   1'b1
`define TWS_SO_IDLE    1'b1
`define TWS_RDATA_RST  8'h00
`define TWS_HOLD_RST   1'b1

`endif

// >>> src/tws_pkg.sv
// types shared by the three-wire serial port files
package tws_pkg;

	// ****************************************************************
	// data and state types
	// ****************************************************************
	typedef logic [7:0] tws_byte_t;

	typedef enum logic [1:0]
	{
		TWS_IDLE,
		TWS_INT_RUN,
		TWS_EXT_RUN
	} tws_state_t;

endpackage

// >>> src/tws_link_if.sv
// signals between the system-clock control and the serial-clock shifter
interface tws_link_if;

	logic                hold;
	tws_pkg::tws_byte_t  tx_byte;
	tws_pkg::tws_byte_t  rx_byte;
	logic                done;
	logic                so;

	modport sys
	(
		output hold,
		output tx_byte,
		input  rx_byte,
		input  done,
		input  so
	);

	modport link
	(
		input  hold,
		input  tx_byte,
		output rx_byte,
		output done,
		output so
	);

endinterface

// >>> src/tws_link_shifter.sv
// shifter running on the externally supplied serial clock
`include "tws_map.svh"

module tws_link_shifter
(
	input  wire logic  sck,
	input  wire logic  si,
	tws_link_if.link   lk
);

	// ****************************************************************
	// storage
	// ****************************************************************
	logic [3:0]          cnt_q;
	logic                done_q;
	tws_pkg::tws_byte_t  rx_q;
	logic                so_q;
	logic [2:0]          bit_sel;

	assign bit_sel    = ~cnt_q[2:0];
	assign lk.rx_byte = rx_q;
	assign lk.done    = done_q;
	assign lk.so      = so_q;

	// ****************************************************************
	// rising edges: count and sample
	// ****************************************************************
	// hold clears the counter, so the first pulse after release is bit one
	always_ff @(posedge sck or posedge lk.hold)
	begin
		if (lk.hold)
		begin
			cnt_q  <= `TWS_CNT_ZERO;
			done_q <= 1'b0;
		end
		else if (!done_q)
		begin
			cnt_q <= cnt_q + `TWS_CNT_ONE;
			if (cnt_q == `TWS_LAST_BIT)
			begin
				done_q <= 1'b1;
			end
		end
	end

	// local capture only; the shared register takes it at completion
	always_ff @(posedge sck)
	begin
		if (!done_q)
		begin
			rx_q <= {rx_q[6:0], si};
		end
	end

	// ****************************************************************
	// falling edges: drive next bit, msb first
	// ****************************************************************
	always_ff @(negedge sck)
	begin
		if (!lk.hold && !done_q)
		begin
			so_q <= lk.tx_byte[bit_sel];
		end
	end

endmodule

// >>> verification/tws_serial_io_sva.sv
// concurrent checks on the ports of the three-wire serial port
module tws_serial_io_sva
(
	input wire logic clk,
	input wire logic rst,
	input wire logic tx_enable_bit,
	input wire logic rx_enable_bit,
	input wire logic ext_clk_sel,
	input wire logic wr_strobe,
	input wire logic busy,
	input wire logic transfer_done_irq,
	input wire logic sck_o,
	input wire logic so_o,
	input wire logic so_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [3:0] rise_q;
	logic [3:0] idle_q;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	// rises of the internal clock in this frame, idle cycles since a frame
	always_ff @(posedge clk)
	begin
		rise_q <= (!busy || rst) ? 4'h0 : rise_q + {3'h0, $rose(sck_o)};
		idle_q <= (busy || rst) ? 4'h0 : idle_q + {3'h0, idle_q != 4'hF};
	end

	property p_sck_idle;
		!busy && !ext_clk_sel |-> sck_o;
	endproperty
	a_sck_idle: assert property (p_sck_idle) else $error("sck low idle");
	property p_so_float;
		!$past(rst) |-> so_oe == $past(tx_enable_bit);
	endproperty
	a_so_float: assert property (p_so_float) else $error("so_oe wrong");
	property p_irq_rise;
		transfer_done_irq && !ext_clk_sel |-> $rose(sck_o) && $fell(busy);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq edge");
	property p_irq_eighth;
		transfer_done_irq && !ext_clk_sel |-> rise_q == 4'h7;
	endproperty
	a_irq_eighth: assert property (p_irq_eighth) else $error("irq count");
	property p_sck_hold;
		transfer_done_irq && !ext_clk_sel |=> sck_o [*3];
	endproperty
	a_sck_hold: assert property (p_sck_hold) else $error("sck not held");
	property p_wr_start;
		!busy && wr_strobe && tx_enable_bit |=> busy;
	endproperty
	a_wr_start: assert property (p_wr_start) else $error("no wr start");
	property p_rx_start;
		!busy && rx_enable_bit && !$past(rx_enable_bit) && !$past(rst) |=> busy;
	endproperty
	a_rx_start: assert property (p_rx_start) else $error("no rx start");
	property p_first_fall;
		$rose(busy) && !ext_clk_sel |-> ##[1:6] $fell(sck_o);
	endproperty
	a_first_fall: assert property (p_first_fall) else $error("late fall");
	property p_so_still;
		ext_clk_sel && $past(ext_clk_sel, 2) && idle_q > 4'h8 |-> $stable(so_o);
	endproperty
	a_so_still: assert property (p_so_still) else $error("so moved");

	cover property (transfer_done_irq && !ext_clk_sel);
	cover property (transfer_done_irq && ext_clk_sel);
	cover property ($fell(busy) && !transfer_done_irq);
endmodule

// >>> verification/tws_peer.sv
// far-side serial device: clock source in external mode, data both ways
module tws_peer
(
	input  wire logic       sck_o,
	input  wire logic       so_o,
	input  wire logic       so_oe,
	input  wire logic       ext,
	input  wire logic       go,
	input  wire logic [7:0] tx,
	output logic            sck_link,
	output logic            si,
	output logic      [7:0] rx
);
	timeunit 1ns;
	timeprecision 100ps;
	logic       sck;
	logic [3:0] n;

	assign sck = ext ? sck_link : sck_o;

	initial
	begin
		sck_link = 1'b1;
		si = 1'b0;
		n = 4'h0;
	end

	// eight pulses per frame, clock stands high between frames
	always @(posedge go)
	begin
		n = 4'h0;
		if (ext)
			repeat (8)
			begin
				#7.5 sck_link = 1'b0;
				#7.5 sck_link = 1'b1;
			end
	end

	always @(negedge sck)
	begin
		si = (n < 4'h8) ? tx[3'h7 - n[2:0]] : ~si;
		n = n + 4'h1;
	end

	always @(posedge sck)
		rx = {rx[6:0], so_oe ? so_o : 1'bz};
endmodule

// >>> verification/tb.sv
// self-checking bench of the three-wire serial port
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       clk, rst, sck_link, si, tx_en, rx_en, ext, wr, rd, go, seen;
	logic       busy, irq, sck_o, sck_oe, so_o, so_oe;
	logic [7:0] wdat, pdat, rd_data, prx;
	int         failures, comparisons, seed;

	tws_serial_io #(.DIV_HALF(8'h03)) i_tws_serial_io (.clk(clk), .rst(rst),
		.ce(1'b1), .sck_link(sck_link), .si(si), .tx_enable_bit(tx_en),
		.rx_enable_bit(rx_en), .ext_clk_sel(ext), .wr_strobe(wr),
		.wr_data(wdat), .rd_strobe(rd), .rd_data(rd_data), .busy(busy),
		.transfer_done_irq(irq), .sck_o(sck_o), .sck_oe(sck_oe),
		.so_o(so_o), .so_oe(so_oe));
	tws_peer i_tws_peer (.sck_o(sck_o), .so_o(so_o), .so_oe(so_oe),
		.ext(ext), .go(go), .tx(pdat), .sck_link(sck_link), .si(si),
		.rx(prx));

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic check(string what, logic [7:0] seen_v, logic [7:0] exp);
		comparisons++;
		if (seen_v !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen_v);
		end
	endtask

	task automatic conclude;
		if (failures == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic wait_irq(int lim, output logic hit);
		hit = 1'b0;
		for (int i = 0; i < lim && !hit; i++)
		begin
			@(negedge clk);
			hit = (irq === 1'b1);
		end
	endtask

	task automatic start(logic [1:0] m, logic e, logic rds, logic [7:0] d);
		@(negedge clk);
		if (!rds)
			{tx_en, rx_en, ext} = {2'b00, e};
		wdat = d;
		pdat = 8'($random(seed));
		wr = (m == 2'h3);
		@(negedge clk);
		wr = 1'b0;
		go = !e;
		{rx_en, tx_en} = m;
		@(negedge clk);
		go = 1'b0;
		wr = (m == 2'h1);
		rd = rds;
		@(negedge clk);
		{wr, rd} = 2'b00;
		if (e)
		begin
			repeat (4) @(negedge clk);
			go = 1'b1;
		end
	endtask

	task automatic xfer(logic [1:0] m, logic e, logic rds, logic [7:0] d);
		logic hit;
		start(m, e, rds, d);
		wait_irq(300, hit);
		if (!hit)
		begin
			failures++;
			conclude();
		end
		go = 1'b0;
		repeat (2) @(negedge clk);
		check("rd_data", rd_data, pdat);
		if (m[0])
			check("peer rx", prx, wdat);
		check("so_oe", {7'h0, so_oe}, {7'h0, m[0]});
		check("sck_oe", {7'h0, sck_oe}, {7'h0, !e});
	endtask

	task automatic abort(logic e);
		logic hit;
		start(2'h3, e, 1'b0, 8'hA5);
		repeat (e ? 1 : 10) @(negedge clk);
		{tx_en, rx_en} = 2'b00;
		wait_irq(60, hit);
		go = 1'b0;
		check("irq", {7'h0, hit}, 8'h00);
		check("so_oe", {7'h0, so_oe}, 8'h00);
		check("busy", {7'h0, busy}, 8'h00);
	endtask

	initial
	begin
		seed = 32'hd9d0b448;
		{rst, tx_en, rx_en, ext, wr, rd, go} = 7'b1000000;
		{wdat, pdat} = 16'h0000;
		failures = 0;
		comparisons = 0;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		check("sck_o", {7'h0, sck_o}, 8'h01);
		xfer(2'h1, 1'b0, 1'b0, 8'h80);
		xfer(2'h3, 1'b1, 1'b0, 8'h01);
		for (int j = 0; j < 6; j++)
			xfer(2'(j % 3 + 1), j > 2, 1'b0, 8'($random(seed)));
		xfer(2'h2, 1'b0, 1'b0, 8'($random(seed)));
		xfer(2'h2, 1'b0, 1'b1, 8'($random(seed)));
		@(negedge clk);
		{tx_en, rx_en, ext} = 3'b001;
		@(negedge clk);
		{tx_en, rx_en, ext} = 3'b101;
		repeat (10) @(negedge clk);
		go = 1'b1;
		wait_irq(20, seen);
		go = 1'b0;
		check("irq", {7'h0, seen}, 8'h00);
		check("rd_data", rd_data, pdat);
		start(2'h3, 1'b0, 1'b0, 8'h3C);
		repeat (10) @(negedge clk);
		tx_en = 1'b0;
		wait_irq(60, seen);
		repeat (2) @(negedge clk);
		check("irq", {7'h0, seen}, 8'h01);
		check("rd_data", rd_data, pdat);
		check("so_oe", {7'h0, so_oe}, 8'h00);
		abort(1'b0);
		abort(1'b1);
		xfer(2'h3, 1'b1, 1'b0, 8'($random(seed)));
		conclude();
	end
endmodule

bind tws_serial_io tws_serial_io_sva i_tws_serial_io_sva (.*);
